// ==== acc_pkg.sv ====
/*
  Constants for the comparator control block: register addresses, field
  positions and reset values.
  Assumes an 8-bit special-function-register bus with an 8-bit address.
*/
package acc_pkg;
  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h9b;
  localparam logic [7:0] ADDR_CTRL = 8'h9a;
  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int MODE_RISE_IE_BIT = 5;
  localparam int MODE_FALL_IE_BIT = 4;
  localparam int MODE_SEL_LSB     = 0;
  localparam logic [1:0] MODE_SEL_RESET  = 2'h2;
  localparam logic [7:0] MODE_RESET      = 8'h02;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_OUT_BIT   = 6;
  localparam int CTRL_RISE_BIT  = 5;
  localparam int CTRL_FALL_BIT  = 4;
  localparam int CTRL_HYP_LSB   = 2;
  localparam int CTRL_HYN_LSB   = 0;
  localparam logic [1:0] HYST_OFF     = 2'h0;
  localparam logic       EN_RESET     = 1'b0;
  localparam logic       SYNC_SEL_RESET = 1'b1;
endpackage

// ==== acc_sync.sv ====
/*
  Two-flop synchroniser for the asynchronous comparator output.
  Assumes the input is a level from the analog domain.
*/
module acc_sync
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_ff;
  logic nxt_meta;
  logic sync_ff;
  logic nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule // acc_sync

// ==== acc_ctrl.sv ====
/*
  Comparator control and status: mode register, control register with
  enable, hysteresis selects and sticky edge flags, interrupt request and
  port-pin output routing.
  Assumes a byte-wide register port with one-cycle read and write strobes
  and an analog comparator whose raw output is asynchronous.
*/
// Summary of operation
// - Falling-edge flag sets on a high-to-low comparator output transition.
// - Rising-edge flag sets on a low-to-high comparator output transition.
// - Edge flags stay set until software writes them to zero.
// - Read-only output state bit shows the live output, no side effects.
// - Enable bit one turns comparator on, zero turns it off.
// - Disabled: pin output driven low and analog power removed.
// - Pin output selectable registered or unregistered; unregistered needs no clock.
// - Mode bit 5 is the rising-edge interrupt enable, reset zero.
// - Mode bit 4 is the falling-edge interrupt enable, reset zero.
// - Mode bits 1:0 select response mode 0..3, reset mode 2.
// - Mode bits 7:6 and 3:2 read zero, writes ignored.
// - Control holds two-bit hysteresis selects; code 00 means no hysteresis.
// - Interrupts on both edges, each direction enabled independently.
module acc_ctrl
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       cmp_raw_in,
  input  wire logic       pin_sync_sel_in,
  output logic            cmp_power_out,
  output logic      [1:0] response_mode_select_out,
  output logic      [1:0] positive_hysteresis_select_out,
  output logic      [1:0] negative_hysteresis_select_out,
  output logic            cmp_pin_out,
  output logic            cmp_irq_out
);
  // ----------------------------------------------------------------------
  // Synchronised comparator output
  // ----------------------------------------------------------------------
  logic cmp_sync;
  logic prev_ff;
  logic nxt_prev;
  logic rise_evt;
  logic fall_evt;

  acc_sync u_sync
  (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .async_in   (cmp_raw_in),
    .sync_out   (cmp_sync)
  );

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       enable_ff;
  logic       nxt_enable;
  logic       rising_edge_flag_ff;
  logic       nxt_rising_edge_flag;
  logic       falling_edge_flag_ff;
  logic       nxt_falling_edge_flag;
  logic [1:0] hyp_ff;
  logic [1:0] nxt_hyp;
  logic [1:0] hyn_ff;
  logic [1:0] nxt_hyn;
  logic       rise_ie_ff;
  logic       nxt_rise_ie;
  logic       fall_ie_ff;
  logic       nxt_fall_ie;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       pin_sync_ff;
  logic       nxt_pin_sync;
  logic       wr_ctrl;
  logic       wr_mode;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == acc_pkg::ADDR_CTRL);
  assign wr_mode = reg_wr_in && (reg_addr_in == acc_pkg::ADDR_MODE);

  // Edges only count while enabled, so a power-up glitch is ignored
  assign rise_evt = enable_ff && cmp_sync && !prev_ff;
  assign fall_evt = enable_ff && !cmp_sync && prev_ff;

  always_comb
  begin
    nxt_prev              = cmp_sync;
    nxt_enable            = enable_ff;
    nxt_hyp               = hyp_ff;
    nxt_hyn               = hyn_ff;
    nxt_rise_ie           = rise_ie_ff;
    nxt_fall_ie           = fall_ie_ff;
    nxt_mode              = mode_ff;
    nxt_rising_edge_flag  = rising_edge_flag_ff;
    nxt_falling_edge_flag = falling_edge_flag_ff;
    nxt_pin_sync          = cmp_sync && enable_ff;
    nxt_rdata             = rdata_ff;
    if (wr_ctrl)
    begin
      nxt_enable            = reg_wdata_in[acc_pkg::CTRL_EN_BIT];
      nxt_rising_edge_flag  = reg_wdata_in[acc_pkg::CTRL_RISE_BIT];
      nxt_falling_edge_flag = reg_wdata_in[acc_pkg::CTRL_FALL_BIT];
      nxt_hyp = reg_wdata_in[acc_pkg::CTRL_HYP_LSB +: 2];
      nxt_hyn = reg_wdata_in[acc_pkg::CTRL_HYN_LSB +: 2];
    end
    if (wr_mode)
    begin
      nxt_rise_ie = reg_wdata_in[acc_pkg::MODE_RISE_IE_BIT];
      nxt_fall_ie = reg_wdata_in[acc_pkg::MODE_FALL_IE_BIT];
      nxt_mode    = reg_wdata_in[acc_pkg::MODE_SEL_LSB +: 2];
    end
    // Hardware set wins over a simultaneous software clear
    if (rise_evt)
    begin
      nxt_rising_edge_flag = 1'b1;
    end
    if (fall_evt)
    begin
      nxt_falling_edge_flag = 1'b1;
    end
    if (reg_rd_in)
    begin
      nxt_rdata = 8'h00;
      if (reg_addr_in == acc_pkg::ADDR_CTRL)
      begin
        nxt_rdata[acc_pkg::CTRL_EN_BIT]        = enable_ff;
        nxt_rdata[acc_pkg::CTRL_OUT_BIT]       = cmp_sync;
        nxt_rdata[acc_pkg::CTRL_RISE_BIT]      = rising_edge_flag_ff;
        nxt_rdata[acc_pkg::CTRL_FALL_BIT]      = falling_edge_flag_ff;
        nxt_rdata[acc_pkg::CTRL_HYP_LSB +: 2]  = hyp_ff;
        nxt_rdata[acc_pkg::CTRL_HYN_LSB +: 2]  = hyn_ff;
      end
      else if (reg_addr_in == acc_pkg::ADDR_MODE)
      begin
        // Unused bits stay zero
        nxt_rdata[acc_pkg::MODE_RISE_IE_BIT]   = rise_ie_ff;
        nxt_rdata[acc_pkg::MODE_FALL_IE_BIT]   = fall_ie_ff;
        nxt_rdata[acc_pkg::MODE_SEL_LSB +: 2]  = mode_ff;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      prev_ff              <= 1'b0;
      enable_ff            <= acc_pkg::EN_RESET;
      hyp_ff               <= acc_pkg::HYST_OFF;
      hyn_ff               <= acc_pkg::HYST_OFF;
      rise_ie_ff           <= 1'b0;
      fall_ie_ff           <= 1'b0;
      mode_ff              <= acc_pkg::MODE_SEL_RESET;
      rising_edge_flag_ff  <= 1'b0;
      falling_edge_flag_ff <= 1'b0;
      pin_sync_ff          <= 1'b0;
      rdata_ff             <= 8'h00;
    end
    else
    begin
      prev_ff              <= nxt_prev;
      enable_ff            <= nxt_enable;
      hyp_ff               <= nxt_hyp;
      hyn_ff               <= nxt_hyn;
      rise_ie_ff           <= nxt_rise_ie;
      fall_ie_ff           <= nxt_fall_ie;
      mode_ff              <= nxt_mode;
      rising_edge_flag_ff  <= nxt_rising_edge_flag;
      falling_edge_flag_ff <= nxt_falling_edge_flag;
      pin_sync_ff          <= nxt_pin_sync;
      rdata_ff             <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_out                  = rdata_ff;
  assign cmp_power_out                  = enable_ff;
  assign response_mode_select_out       = mode_ff;
  assign positive_hysteresis_select_out = hyp_ff;
  assign negative_hysteresis_select_out = hyn_ff;
  // Raw path is pure gating so it works with the clock stopped
  assign cmp_pin_out = pin_sync_sel_in ? pin_sync_ff : (cmp_raw_in && enable_ff);
  assign cmp_irq_out = (rising_edge_flag_ff && rise_ie_ff)
                    || (falling_edge_flag_ff && fall_ie_ff);
endmodule // acc_ctrl

// ==== acc_ctrl_chk.sv ====
/* Port checker for acc_ctrl.
   Bound to every acc_ctrl instance; sees its ports only. */
module acc_chk
(
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       cmp_raw_in,
  input wire logic       pin_sync_sel_in,
  input wire logic       cmp_power_out,
  input wire logic [1:0] response_mode_select_out,
  input wire logic [1:0] positive_hysteresis_select_out,
  input wire logic [1:0] negative_hysteresis_select_out,
  input wire logic       cmp_pin_out,
  input wire logic       cmp_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire logic wc = reg_wr_in && reg_addr_in == acc_pkg::ADDR_CTRL;
  wire logic wm = reg_wr_in && reg_addr_in == acc_pkg::ADDR_MODE;
  pwr_wr_a: assert property (wc |=> cmp_power_out == $past(reg_wdata_in[7]))
    else $error("power bit not taken");
  mode_wr_a: assert property (wm |=> response_mode_select_out == $past(reg_wdata_in[1:0]))
    else $error("mode field not taken");
  hyp_wr_a: assert property (wc |=> positive_hysteresis_select_out == $past(reg_wdata_in[3:2]))
    else $error("positive select not taken");
  hyn_wr_a: assert property (wc |=> negative_hysteresis_select_out == $past(reg_wdata_in[1:0]))
    else $error("negative select not taken");
  pin_off_a: assert property (!cmp_power_out [*2] |-> !cmp_pin_out)
    else $error("pin driven while off");
  raw_pin_a: assert property (cmp_power_out && !pin_sync_sel_in |-> cmp_pin_out == cmp_raw_in)
    else $error("raw pin path wrong");
  mode_unused_a: assert property (reg_rd_in && reg_addr_in == acc_pkg::ADDR_MODE
    |=> reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[3:2] == 2'h0)
    else $error("unused mode bits set");
  irq_hold_a: assert property ($fell(cmp_irq_out) |-> $past(reg_wr_in))
    else $error("request dropped without write");
  cover property ($rose(cmp_irq_out));
  cover property (cmp_power_out && $fell(cmp_pin_out));
  cover property (wm ##1 reg_rd_in);
endmodule // acc_chk

bind acc_ctrl acc_chk u_chk (.*);

// ==== acc_ctrl_test.sv ====
/* Self-checking bench for acc_ctrl against a register-level model.
   Assumes the port checker is bound from its own file. */
module acc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic       cmp_raw_in = 0, pin_sync_sel_in = acc_pkg::SYNC_SEL_RESET;
  logic       cmp_power_out, cmp_pin_out, cmp_irq_out;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d;
  logic [1:0] response_mode_select_out, positive_hysteresis_select_out;
  logic [1:0] negative_hysteresis_select_out;
  logic       en = 0, out = 0, rf = 0, ff = 0;
  logic [3:0] lo = 4'h0;
  logic [7:0] mode = acc_pkg::MODE_RESET;
  int         n_errors = 0, checked = 0, cyc = 0;
  acc_ctrl DUT (.*);
  initial forever #5 clk_sys_in = ~clk_sys_in;
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic ck(string n, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, v, 1'b1};
    tick();
    reg_wr_in = 0;
    tick();
    if (a == acc_pkg::ADDR_CTRL) {en, rf, ff, lo} = {v[7], v[5], v[4], v[3:0]};
    if (a == acc_pkg::ADDR_MODE) mode = v & 8'h33;
  endtask
  task automatic rd(string n, logic [7:0] a, logic [7:0] e);
    {reg_addr_in, reg_rd_in} = {a, 1'b1};
    tick();
    reg_rd_in = 0;
    ck(n, reg_rdata_out, e);
    tick();
  endtask
  task automatic outs;
    ck("power", cmp_power_out, en);
    ck("mode", response_mode_select_out, mode[1:0]);
    ck("hyp", positive_hysteresis_select_out, lo[3:2]);
    ck("hyn", negative_hysteresis_select_out, lo[1:0]);
    ck("irq", cmp_irq_out, (rf & mode[5]) | (ff & mode[4]));
    ck("pin", cmp_pin_out, en & out);
    rd("ctrl", acc_pkg::ADDR_CTRL, {en, out, rf, ff, lo});
    rd("mode", acc_pkg::ADDR_MODE, mode);
  endtask
  task automatic cmp(logic v);
    cmp_raw_in = v;
    repeat (4) tick();
    if (en && v !== out) {rf, ff} = {rf | v, ff | !v};
    out = v;
    outs();
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    d = $urandom(32'hb6b1be51);
    repeat (4) @(posedge clk_sys_in);
    #1 reset_in = 0;
    outs();
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom();
      wr(acc_pkg::ADDR_MODE, {d[7:2], i[1:0]});
      outs();
    end
    d = $urandom();
    // Bit 6 is read-only: writing one there must not show up
    wr(acc_pkg::ADDR_CTRL, {4'hc, d[3:0]});
    outs();
    wr(8'h55, 8'hff);
    wr(acc_pkg::ADDR_MODE, 8'h30);
    cmp(1);
    cmp(0);
    cmp(1);
    wr(acc_pkg::ADDR_CTRL, {4'h8, lo});
    outs();
    // Falling edge lands in the same cycle as a clearing write: set wins
    cmp_raw_in = 0;
    repeat (2) tick();
    wr(acc_pkg::ADDR_CTRL, {4'h8, lo});
    {ff, out} = 2'b10;
    outs();
    wr(acc_pkg::ADDR_MODE, 8'h20);
    cmp(0);
    cmp(1);
    pin_sync_sel_in = 0;
    cmp(0);
    cmp(1);
    wr(acc_pkg::ADDR_CTRL, 8'h00);
    ck("pin_off", cmp_pin_out, 8'h00);
    pin_sync_sel_in = 1;
    repeat (3) tick();
    ck("pin_off", cmp_pin_out, 8'h00);
    ck("power", cmp_power_out, 8'h00);
    rd("unmapped", 8'h55, 8'h00);
    end_sim();
  end
endmodule // acc_ctrl_test
